// ==== rtl/pcr_pkg.sv ====
// constants and types for the clock and reset control block
package pcr_pkg;
  // ******************************************************************
  // register map
  // ******************************************************************
  localparam logic [7:0] ADDR_PWR = 8'h00; // power and reset control
  localparam logic [7:0] ADDR_PLL = 8'h01; // pll control
  localparam int PWR_SRST_BIT = 7; // software reset, self clearing
  localparam int PLL_LOCK_BIT = 7; // lock flag, read only
  localparam int PLL_SRC_BIT = 4; // 1 = frame clock reference
  localparam int PLL_EN_BIT = 3; // pll enable
  localparam int MCS_LSB = 0; // ratio field low bit
  localparam int MCS_W = 3; // ratio field width
  localparam logic [7:0] PWR_RESET = 8'h00; // power register at reset
  localparam logic [7:0] PLL_RESET = 8'h00; // pll register at reset
  localparam logic [7:0] PWR_WMASK = 8'h7F; // storable power bits
  localparam logic [7:0] PLL_WMASK = 8'h1F; // storable pll bits
  localparam logic [2:0] MCS_MAX = 3'h4; // highest defined ratio code
  // ******************************************************************
  // ratios and timing
  // ******************************************************************
  localparam logic [9:0] RATIO_0 = 10'h080; // 128 x fs
  localparam logic [9:0] RATIO_1 = 10'h100; // 256 x fs
  localparam logic [9:0] RATIO_2 = 10'h180; // 384 x fs
  localparam logic [9:0] RATIO_3 = 10'h200; // 512 x fs
  localparam logic [9:0] RATIO_4 = 10'h300; // 768 x fs
  localparam int CLK_HZ = 100000000; // system clock rate
  localparam int RATE_MIN_HZ = 32000; // slowest frame clock
  localparam int RATE_MAX_HZ = 192000; // fastest frame clock
  localparam int PER_MAX = CLK_HZ / RATE_MIN_HZ; // longest period
  localparam int PER_MIN = (CLK_HZ + RATE_MAX_HZ - 1) / RATE_MAX_HZ;
  localparam int PER_W = 12; // period counter width
  // ******************************************************************
  // pin indices in the synchroniser vector
  // ******************************************************************
  localparam int PIN_RST_N = 0; // power-down reset, active low
  localparam int PIN_MCLK = 1; // master clock input
  localparam int PIN_FCLK = 2; // frame clock
  localparam int PIN_UPPER = 3; // core supply above upper trip
  localparam int PIN_LOWER = 4; // core supply below lower trip
  localparam int PIN_N = 5; // number of synchronised pins
  // ******************************************************************
  // types
  // ******************************************************************
  typedef struct packed {
    logic wr; // write strobe
    logic rd; // read strobe
    logic [7:0] addr; // register offset
    logic [7:0] wdata; // write data
  } pcr_reg_req_t;
  typedef struct packed {
    logic rvalid; // read data valid pulse
    logic [7:0] rdata; // read data
  } pcr_reg_rsp_t;
  typedef struct packed {
    logic pll_enable; // pll running
    logic pll_ref_frame; // reference is frame clock
    logic serial_slave_req; // serial port must be slave
    logic [9:0] mult_ratio; // master clock multiplication ratio
  } pcr_pll_cfg_t;
  typedef enum logic [1:0] {
    PCR_OFF = 2'b00,
    PCR_CHARGE = 2'b01,
    PCR_RUN = 2'b11
  } pcr_por_t;
endpackage : pcr_pkg

// ==== rtl/pcr_clock_reset.sv ====
// clock source, ratio, lock and reset sequencing for the converter core
//
// Behaviour
// - source bit picks master or frame clock
// - frame clock reference forces serial slave
// - frame reference locks only at 32-192 kHz
// - ratio code sets 128 to 768 times fs, shifted down by the rate band
// - lock flag readable in pll register
// - software reset bit resets registers, lock and core
// - reset pin low disables core regulator
// - core held reset until upper supply trip
// - core resets again only below lower trip or by software reset
// - reference output off during power-down and supply reset, not software reset
// - reset pin is active low
`timescale 1ns/1ps
`default_nettype none
module pcr_clock_reset #(
  parameter int LOCK_EDGES = 16 // reference edges needed to lock
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins and supply comparators
  input wire logic power_down_reset_n,
  input wire logic master_clock_input,
  input wire logic frame_clock,
  input wire logic core_above_upper,
  input wire logic core_below_lower,
  // sample rate band: 0 base, 1 double, 2 quad
  input wire logic [1:0] fs_band,
  // register port
  input wire pcr_pkg::pcr_reg_req_t reg_req,
  output pcr_pkg::pcr_reg_rsp_t reg_rsp,
  // power and reset controls
  output logic core_supply_output,
  output logic vref_enable,
  output logic core_reset,
  // pll configuration
  output pcr_pkg::pcr_pll_cfg_t pll_cfg,
  output logic pll_locked
);
  // ******************************************************************
  // helpers
  // ******************************************************************
  // base ratio for a ratio code
  function automatic logic [9:0] ratio_of(input logic [2:0] code);
    case (code)
      3'h0: ratio_of = pcr_pkg::RATIO_0;
      3'h1: ratio_of = pcr_pkg::RATIO_1;
      3'h2: ratio_of = pcr_pkg::RATIO_2;
      3'h3: ratio_of = pcr_pkg::RATIO_3;
      3'h4: ratio_of = pcr_pkg::RATIO_4;
      default: ratio_of = 10'h000;
    endcase
  endfunction : ratio_of

  // rising edge of a filtered level
  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction : rise

  // ******************************************************************
  // pin synchronisers
  // ******************************************************************
  logic [pcr_pkg::PIN_N-1:0] pins; // raw pin vector
  logic [pcr_pkg::PIN_N-1:0] s1_q; // first stage, read by s2 only
  logic [pcr_pkg::PIN_N-1:0] s2_q; // second stage
  logic [pcr_pkg::PIN_N-1:0] s3_q; // third stage
  logic [pcr_pkg::PIN_N-1:0] f_q, f_d; // filtered levels
  assign pins = {core_below_lower, core_above_upper, frame_clock,
                 master_clock_input, power_down_reset_n};

  // a change counts once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < pcr_pkg::PIN_N; i++)
    begin
      f_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : f_q[i];
    end
  end

  // synchroniser and filter registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      f_q <= '0;
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= f_d;
    end
  end

  logic pin_high; // reset pin released
  logic upper_f; // supply above upper trip
  logic lower_f; // supply below lower trip
  assign pin_high = f_q[pcr_pkg::PIN_RST_N];
  assign upper_f = f_q[pcr_pkg::PIN_UPPER];
  assign lower_f = f_q[pcr_pkg::PIN_LOWER];

  // ******************************************************************
  // power-on reset sequencing
  // ******************************************************************
  pcr_pkg::pcr_por_t por_q, por_d; // supply state
  logic srst_q, srst_d; // software reset pulse
  logic run; // core out of reset
  assign run = (por_q == pcr_pkg::PCR_RUN);

  // regulator charge, threshold release and hysteresis
  always_comb
  begin
    por_d = por_q;
    case (por_q)
      pcr_pkg::PCR_OFF:
      begin
        if (pin_high)
          por_d = pcr_pkg::PCR_CHARGE;
      end
      pcr_pkg::PCR_CHARGE:
      begin
        if (!pin_high)
          por_d = pcr_pkg::PCR_OFF;
        else if (upper_f)
          por_d = pcr_pkg::PCR_RUN;
      end
      pcr_pkg::PCR_RUN:
      begin
        // only a fall below the lower trip takes the core out of run
        if (lower_f)
          por_d = pin_high ? pcr_pkg::PCR_CHARGE : pcr_pkg::PCR_OFF;
      end
      default: por_d = pcr_pkg::PCR_OFF;
    endcase
  end

  // ******************************************************************
  // registers and register port
  // ******************************************************************
  logic [7:0] pwr_q, pwr_d; // power and reset control
  logic [7:0] pll_q, pll_d; // pll control, stored bits
  pcr_pkg::pcr_reg_rsp_t rsp_q, rsp_d; // read answer
  logic lock_q, lock_d; // lock flag
  logic wr_pwr, wr_pll, rd_ok; // decoded strobes
  assign wr_pwr = reg_req.wr && run && reg_req.addr == pcr_pkg::ADDR_PWR;
  assign wr_pll = reg_req.wr && run && reg_req.addr == pcr_pkg::ADDR_PLL;
  assign rd_ok = reg_req.rd && run;

  // writes, software reset and reads
  always_comb
  begin
    pwr_d = pwr_q;
    pll_d = pll_q;
    srst_d = 1'b0;
    rsp_d = '0;
    if (!run || srst_q)
    begin
      // core in reset: registers back to defaults
      pwr_d = pcr_pkg::PWR_RESET;
      pll_d = pcr_pkg::PLL_RESET;
    end
    else
    begin
      if (wr_pwr)
      begin
        pwr_d = reg_req.wdata & pcr_pkg::PWR_WMASK;
        srst_d = reg_req.wdata[pcr_pkg::PWR_SRST_BIT];
      end
      if (wr_pll)
        pll_d = reg_req.wdata & pcr_pkg::PLL_WMASK;
      if (rd_ok)
      begin
        rsp_d.rvalid = 1'b1;
        case (reg_req.addr)
          pcr_pkg::ADDR_PWR: rsp_d.rdata = pwr_q;
          pcr_pkg::ADDR_PLL:
          begin
            rsp_d.rdata = pll_q;
            rsp_d.rdata[pcr_pkg::PLL_LOCK_BIT] = lock_q;
          end
          default: rsp_d.rdata = 8'h00;
        endcase
      end
    end
  end

  // ******************************************************************
  // reference selection, rate check and lock detection
  // ******************************************************************
  logic ref_frame; // frame clock selected
  logic pll_en; // pll enabled
  logic [2:0] mclk_ratio_select; // ratio code
  logic ref_lvl, fclk_lvl; // selected and frame levels
  logic ref_was_q, fclk_was_q; // previous levels
  logic [pcr_pkg::PER_W-1:0] per_q, per_d; // frame period counter
  logic rate_ok_q, rate_ok_d; // frame rate within range
  logic [7:0] cnt_q, cnt_d; // reference edges seen
  logic cfg_chg; // pll settings changed by a write
  assign ref_frame = pll_q[pcr_pkg::PLL_SRC_BIT];
  assign pll_en = pll_q[pcr_pkg::PLL_EN_BIT];
  assign mclk_ratio_select = pll_q[pcr_pkg::MCS_LSB +: pcr_pkg::MCS_W];
  assign ref_lvl = ref_frame ? f_q[pcr_pkg::PIN_FCLK]
                             : f_q[pcr_pkg::PIN_MCLK];
  assign fclk_lvl = f_q[pcr_pkg::PIN_FCLK];
  assign cfg_chg = wr_pll &&
                   ((reg_req.wdata & pcr_pkg::PLL_WMASK) != pll_q);

  // frame period measurement and lock counting
  always_comb
  begin
    per_d = per_q;
    rate_ok_d = rate_ok_q;
    cnt_d = cnt_q;
    lock_d = lock_q;
    if (rise(fclk_lvl, fclk_was_q))
    begin
      // judge the finished period, start the next
      rate_ok_d = (per_q >= pcr_pkg::PER_W'(pcr_pkg::PER_MIN)) &&
                  (per_q <= pcr_pkg::PER_W'(pcr_pkg::PER_MAX));
      per_d = '0;
    end
    else if (per_q > pcr_pkg::PER_W'(pcr_pkg::PER_MAX))
      rate_ok_d = 1'b0; // frame clock too slow or stopped
    else
      per_d = per_q + 1'b1;
    if (!run || srst_q || !pll_en || cfg_chg || mclk_ratio_select > pcr_pkg::MCS_MAX ||
        (ref_frame && !(rate_ok_q && rate_ok_d)))
    begin
      // lost or never had lock; a failing rate judgement blocks the set
      cnt_d = '0;
      lock_d = 1'b0;
    end
    else if (rise(ref_lvl, ref_was_q))
    begin
      if (cnt_q >= 8'(LOCK_EDGES - 1))
        lock_d = 1'b1;
      else
        cnt_d = cnt_q + 1'b1;
    end
  end

  // ******************************************************************
  // output values
  // ******************************************************************
  pcr_pkg::pcr_pll_cfg_t cfg_d; // next pll configuration
  always_comb
  begin
    cfg_d.pll_enable = pll_en && run;
    cfg_d.pll_ref_frame = ref_frame;
    cfg_d.serial_slave_req = ref_frame;
    cfg_d.mult_ratio = ratio_of(mclk_ratio_select) >> fs_band;
  end

  // state registers other than the pin synchronisers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      por_q <= pcr_pkg::PCR_OFF;
      srst_q <= 1'b0;
      pwr_q <= pcr_pkg::PWR_RESET;
      pll_q <= pcr_pkg::PLL_RESET;
      rsp_q <= '0;
      lock_q <= 1'b0;
      ref_was_q <= 1'b0;
      fclk_was_q <= 1'b0;
      per_q <= '0;
      rate_ok_q <= 1'b0;
      cnt_q <= '0;
      pll_cfg <= '0;
      pll_locked <= 1'b0;
      core_supply_output <= 1'b0;
      vref_enable <= 1'b0;
      core_reset <= 1'b1;
    end
    else
    begin
      por_q <= por_d;
      srst_q <= srst_d;
      pwr_q <= pwr_d;
      pll_q <= pll_d;
      rsp_q <= rsp_d;
      lock_q <= lock_d;
      ref_was_q <= ref_lvl;
      fclk_was_q <= fclk_lvl;
      per_q <= per_d;
      rate_ok_q <= rate_ok_d;
      cnt_q <= cnt_d;
      pll_cfg <= cfg_d;
      pll_locked <= lock_q;
      core_supply_output <= pin_high;
      vref_enable <= pin_high && run;
      core_reset <= !run || srst_q;
    end
  end
  assign reg_rsp = rsp_q;

  // ******************************************************************
  // checks
  // ******************************************************************
  a_source_follows_bit: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(pll_q[pcr_pkg::PLL_SRC_BIT]) |-> ##1
      pll_cfg.pll_ref_frame == $past(pll_q[pcr_pkg::PLL_SRC_BIT]))
    else $error("pll reference does not follow source bit");
  a_frame_needs_slave: assert property (@(posedge clk) disable iff (sys_rst)
    pll_cfg.pll_ref_frame |-> pll_cfg.serial_slave_req)
    else $error("frame reference without slave request");
  a_frame_rate_lock: assert property (@(posedge clk) disable iff (sys_rst)
    lock_q && ref_frame |-> rate_ok_q)
    else $error("locked on out of range frame clock");
  a_ratio_defined: assert property (@(posedge clk) disable iff (sys_rst)
    pll_q[2:0] == 3'h4 && fs_band == 2'h0 |-> ##1
      pll_cfg.mult_ratio == pcr_pkg::RATIO_4)
    else $error("ratio code four not 768");
  a_lock_readback: assert property (@(posedge clk) disable iff (sys_rst)
    rd_ok && reg_req.addr == pcr_pkg::ADDR_PLL && !srst_q |-> ##1
      reg_rsp.rvalid && reg_rsp.rdata[7] == $past(lock_q))
    else $error("lock flag not returned on read");
  a_soft_reset_all: assert property (@(posedge clk) disable iff (sys_rst)
    wr_pwr && !srst_q && reg_req.wdata[pcr_pkg::PWR_SRST_BIT] |-> ##2
      core_reset && pll_q == pcr_pkg::PLL_RESET && !lock_q)
    else $error("software reset did not reset the part");
  a_regulator_off: assert property (@(posedge clk) disable iff (sys_rst)
    !pin_high |-> ##1 !core_supply_output && !vref_enable)
    else $error("supply or reference on while pin low");
  a_por_hysteresis: assert property (@(posedge clk) disable iff (sys_rst)
    run && !lower_f |=> run)
    else $error("core reset without lower trip");
  a_core_held: assert property (@(posedge clk) disable iff (sys_rst)
    !run |-> ##1 core_reset)
    else $error("core released before supply threshold");
  a_lock_disabled: assert property (@(posedge clk) disable iff (sys_rst)
    !pll_en |-> ##1 !lock_q ##1 !pll_locked)
    else $error("lock flag set while pll disabled");
endmodule : pcr_clock_reset
`default_nettype wire

// ==== verif/pcr_host_model.sv ====
// host side clock sources feeding the clock and reset block
`timescale 1ns/1ps
`default_nettype none
module pcr_host_model (
  // source controls from the bench
  input wire logic mclk_on,
  input wire logic fclk_on,
  input wire logic [15:0] fclk_half_ns,
  // clock pins towards the device
  output logic master_clock_input,
  output logic frame_clock
);
  // ****************************************************************
  // clock generation
  // ****************************************************************
  initial master_clock_input = 1'b0;
  initial frame_clock = 1'b0;
  // master clock at 25 mhz, held low while switched off
  always #20 master_clock_input = mclk_on ? ~master_clock_input : 1'b0;
  // frame clock from the external master, low between uses
  always
  begin
    #(fclk_half_ns + 16'h0001);
    frame_clock = fclk_on ? ~frame_clock : 1'b0;
  end
endmodule : pcr_host_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the clock and reset block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic power_down_reset_n = 1'b0; // device held in power-down
  logic core_above_upper = 1'b0;
  logic core_below_lower = 1'b1; // core supply discharged
  logic [1:0] fs_band = 2'h0;
  logic mclk_on = 1'b0;
  logic fclk_on = 1'b0;
  logic [15:0] fclk_half = 16'h2710; // 20 us frame period
  logic master_clock_input;
  logic frame_clock;
  pcr_pkg::pcr_reg_req_t reg_req = '0;
  pcr_pkg::pcr_reg_rsp_t reg_rsp;
  pcr_pkg::pcr_pll_cfg_t pll_cfg;
  logic core_supply_output;
  logic vref_enable;
  logic core_reset;
  logic pll_locked;
  int err_count = 0;
  int n_compared = 0;
  logic [7:0] rd_val; // last register read
  // 100 mhz clock
  always #5 clk = ~clk;
  // device under test, short lock count
  pcr_clock_reset #(.LOCK_EDGES(4)) pcr_clock_reset_inst (
    .clk(clk), .sys_rst(sys_rst), .power_down_reset_n(power_down_reset_n),
    .master_clock_input(master_clock_input), .frame_clock(frame_clock),
    .core_above_upper(core_above_upper),
    .core_below_lower(core_below_lower), .fs_band(fs_band),
    .reg_req(reg_req), .reg_rsp(reg_rsp),
    .core_supply_output(core_supply_output), .vref_enable(vref_enable),
    .core_reset(core_reset), .pll_cfg(pll_cfg), .pll_locked(pll_locked));
  // clock sources of the host
  pcr_host_model pcr_host_model_inst (
    .mclk_on(mclk_on), .fclk_on(fclk_on), .fclk_half_ns(fclk_half),
    .master_clock_input(master_clock_input), .frame_clock(frame_clock));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // single bit compare
  task automatic chk_bit(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit
  // register or ratio value compare
  task automatic chk_val(input string what, input logic [9:0] e,
                         input logic [9:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk_val
  // one register write strobe
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
  endtask : reg_wr
  // one register read, answer awaited a few cycles
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    int i;
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    reg_req <= '0;
    d = 8'hEE;
    for (i = 0; i < 3; i++)
    begin
      #1;
      if (reg_rsp.rvalid === 1'b1)
      begin
        d = reg_rsp.rdata;
        break;
      end
      @(posedge clk);
    end
  endtask : reg_rd
  // selected status output
  function automatic logic pick(input int sel);
    case (sel)
      0: return core_reset;
      1: return core_supply_output;
      default: return pll_locked;
    endcase
  endfunction : pick
  // bounded wait for a status level, then compare
  task automatic wait_bit(input int sel, input logic want, input int lim,
                          input string what);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(posedge clk);
      #1;
      if (pick(sel) === want)
        break;
    end
    chk_bit(what, want, pick(sel));
  endtask : wait_bit
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // power-up sequence, early write refused
  task automatic t_power_up;
    chk_bit("core_reset", 1'b1, core_reset);
    chk_bit("supply", 1'b0, core_supply_output);
    chk_bit("vref", 1'b0, vref_enable);
    @(posedge clk);
    power_down_reset_n <= 1'b1;
    core_below_lower <= 1'b0;
    wait_bit(1, 1'b1, 8, "supply");
    reg_wr(8'h01, 8'h07);
    chk_bit("core_reset", 1'b1, core_reset);
    chk_bit("vref", 1'b0, vref_enable);
    @(posedge clk);
    core_above_upper <= 1'b1;
    wait_bit(0, 1'b0, 10, "core_reset");
    @(posedge clk);
    #1;
    chk_bit("vref", 1'b1, vref_enable);
    reg_rd(8'h01, rd_val);
    chk_val("pll reg", 10'h000, {2'h0, rd_val});
    reg_rd(8'h05, rd_val);
    chk_val("unmapped", 10'h000, {2'h0, rd_val});
  endtask : t_power_up
  // every defined ratio code in every rate band
  task automatic t_ratio;
    logic [9:0] base [5] = '{10'h080, 10'h100, 10'h180, 10'h200, 10'h300};
    int b;
    int c;
    for (b = 0; b < 3; b++)
    begin
      @(posedge clk);
      fs_band <= b[1:0];
      for (c = 0; c < 5; c++)
      begin
        reg_wr(8'h01, {5'h00, c[2:0]});
        repeat (2) @(posedge clk);
        #1;
        chk_val("ratio", base[c] >> b, pll_cfg.mult_ratio);
      end
    end
    @(posedge clk);
    fs_band <= 2'h0;
  endtask : t_ratio
  // lock on the master clock, loss on disable
  task automatic t_mclk_lock;
    mclk_on = 1'b1;
    reg_wr(8'h01, 8'h01);
    reg_wr(8'h01, 8'h09);
    wait_bit(2, 1'b1, 200, "lock");
    reg_rd(8'h01, rd_val);
    chk_val("pll reg", 10'h089, {2'h0, rd_val});
    chk_bit("ref_frame", 1'b0, pll_cfg.pll_ref_frame);
    reg_wr(8'h01, 8'h01);
    wait_bit(2, 1'b0, 4, "lock");
    reg_rd(8'h01, rd_val);
    chk_val("pll reg", 10'h001, {2'h0, rd_val});
  endtask : t_mclk_lock
  // lock on the frame clock alone
  task automatic t_frame_lock;
    mclk_on = 1'b0;
    fclk_on = 1'b1;
    reg_wr(8'h01, 8'h10);
    reg_wr(8'h01, 8'h18);
    repeat (2) @(posedge clk);
    #1;
    chk_bit("ref_frame", 1'b1, pll_cfg.pll_ref_frame);
    chk_bit("slave", 1'b1, pll_cfg.serial_slave_req);
    chk_bit("enable", 1'b1, pll_cfg.pll_enable);
    wait_bit(2, 1'b1, 20000, "lock");
  endtask : t_frame_lock
  // software reset clears registers and lock
  task automatic t_soft_reset;
    reg_wr(8'h00, 8'h05);
    reg_rd(8'h00, rd_val);
    chk_val("pwr reg", 10'h005, {2'h0, rd_val});
    reg_wr(8'h00, 8'h85);
    wait_bit(0, 1'b1, 4, "core_reset");
    wait_bit(0, 1'b0, 4, "core_reset");
    reg_rd(8'h00, rd_val);
    chk_val("pwr reg", 10'h000, {2'h0, rd_val});
    reg_rd(8'h01, rd_val);
    chk_val("pll reg", 10'h000, {2'h0, rd_val});
    chk_bit("lock", 1'b0, pll_locked);
  endtask : t_soft_reset
  // frame clock too slow never locks
  task automatic t_frame_range;
    fclk_half = 16'h4E20;
    reg_wr(8'h01, 8'h10);
    reg_wr(8'h01, 8'h18);
    repeat (16000) @(posedge clk);
    #1;
    chk_bit("lock", 1'b0, pll_locked);
  endtask : t_frame_range
  // core survives pin low until lower trip
  task automatic t_hysteresis;
    @(posedge clk);
    core_above_upper <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk_bit("core_reset", 1'b0, core_reset);
    @(posedge clk);
    power_down_reset_n <= 1'b0;
    wait_bit(1, 1'b0, 8, "supply");
    @(posedge clk);
    #1;
    chk_bit("vref", 1'b0, vref_enable);
    chk_bit("core_reset", 1'b0, core_reset);
    @(posedge clk);
    core_below_lower <= 1'b1;
    wait_bit(0, 1'b1, 8, "core_reset");
  endtask : t_hysteresis
  // ****************************************************************
  // run control
  // ****************************************************************
  // counts and verdict
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    t_power_up();
    t_ratio();
    t_mclk_lock();
    t_frame_lock();
    t_soft_reset();
    t_frame_range();
    t_hysteresis();
    complete_run();
  end
  // watchdog, more than three times the expected run
  initial
  begin
    #1000000;
    err_count++;
    $display("BAD watchdog expected finish seen hang");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
